// ### design/irxcmh_pkg.sv
// shared constants and types for the upper isochronous channel mask block
package irxcmh_pkg;

  // data path widths
  localparam int IRXCMH_DATA_WIDTH = 32;
  localparam int IRXCMH_ADDR_WIDTH = 8;
  localparam int IRXCMH_LANE_COUNT = 4;
  localparam int IRXCMH_LANE_WIDTH = 8;

  // first channel number served by mask bit 0
  localparam int IRXCMH_CHAN_BASE = 32;

  // field positions of the two named channel bits
  localparam int IRXCMH_TOP_BIT = 31;
  localparam int IRXCMH_BOTTOM_BIT = 0;

  // byte offsets of the two aliases
  localparam logic [7:0] IRXCMH_SET_OFFSET = 8'h70;
  localparam logic [7:0] IRXCMH_CLR_OFFSET = 8'h74;

  // value loaded into the mask at reset
  localparam logic [31:0] IRXCMH_MASK_RESET = 32'h0000_0000;

  // value returned for an unmapped read
  localparam logic [31:0] IRXCMH_UNMAPPED_RDATA = 32'h0000_0000;

  // bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } irxcmh_bus_state_e;

endpackage

// ### design/irxcmh_mask_if.sv
// carrier between the bus slave and the mask storage
`timescale 1ns/1ps
`default_nettype none
interface irxcmh_mask_if;
  import irxcmh_pkg::*;
  // bits to turn on, one per mask bit
  logic [IRXCMH_DATA_WIDTH-1:0] set_bits;
  // bits to turn off, one per mask bit
  logic [IRXCMH_DATA_WIDTH-1:0] clr_bits;
  // stored mask as held by the storage
  logic [IRXCMH_DATA_WIDTH-1:0] mask;

  // bus side drives the update requests
  modport ctrl (
    output set_bits,
    output clr_bits,
    input mask
  );

  // storage side owns the mask
  modport bank (
    input set_bits,
    input clr_bits,
    output mask
  );
endinterface
`default_nettype wire

// ### design/irxcmh_mask_bank.sv
// mask storage with per-bit set and clear
`timescale 1ns/1ps
`default_nettype none
module irxcmh_mask_bank
  import irxcmh_pkg::*;
#(
  parameter logic [IRXCMH_DATA_WIDTH-1:0] MASK_RESET = IRXCMH_MASK_RESET
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // update requests and stored mask
  irxcmh_mask_if.bank mif
);

  // stored mask and its next value
  logic [IRXCMH_DATA_WIDTH-1:0] mask_reg;
  logic [IRXCMH_DATA_WIDTH-1:0] mask_next;

  // set wins over clear; the bus never asks both at once anyway
  always_comb begin
    mask_next = (mask_reg & ~mif.clr_bits) | mif.set_bits;
  end

  // mask flops; reset value comes from the MASK_RESET parameter, software must program all bits
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign mif.mask = mask_reg;

  // an untouched bit keeps its value
  a_bank_hold_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (mif.set_bits == '0 && mif.clr_bits == '0) |=> mask_reg == $past(mask_reg))
    else $error("mask changed without a request");

endmodule // irxcmh_mask_bank
`default_nettype wire

// ### design/irxcmh_top.sv
// upper isochronous channel mask: avalon slave and per-channel enables
`timescale 1ns/1ps
`default_nettype none
module irxcmh_top
  import irxcmh_pkg::*;
#(
  parameter logic [IRXCMH_DATA_WIDTH-1:0] MASK_RESET = IRXCMH_MASK_RESET
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [IRXCMH_ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [IRXCMH_DATA_WIDTH-1:0] avs_writedata,
  input wire logic [IRXCMH_LANE_COUNT-1:0] avs_byteenable,
  output logic [IRXCMH_DATA_WIDTH-1:0] avs_readdata,
  output logic avs_waitrequest,
  // enables toward the isochronous receive logic
  output logic [IRXCMH_DATA_WIDTH-1:0] upper_chan_enable,
  output logic upper_chan_top_enable,
  output logic upper_chan_bottom_enable
);

  // carrier to the mask storage
  irxcmh_mask_if mif ();

  // bus state and its next value
  irxcmh_bus_state_e bus_state_reg;
  irxcmh_bus_state_e bus_state_next;

  // registered bus answers
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [IRXCMH_DATA_WIDTH-1:0] readdata_reg;
  logic [IRXCMH_DATA_WIDTH-1:0] readdata_next;

  // decoded address hits
  logic hit_set;
  logic hit_clr;
  logic hit_any;

  // write data with unselected byte lanes forced to zero
  logic [IRXCMH_DATA_WIDTH-1:0] lane_bits;

  // write is committed only on the acknowledge cycle
  logic commit_write;

  // address decode, if chain in priority order
  // 71h, 72h and the like fall through: only whole-word offsets hit
  always_comb begin
    hit_set = 1'b0;
    hit_clr = 1'b0;
    if (avs_address == IRXCMH_SET_OFFSET) begin
      // set alias
      hit_set = 1'b1;
    end else if (avs_address == IRXCMH_CLR_OFFSET) begin
      // clear alias
      hit_clr = 1'b1;
    end
    hit_any = hit_set | hit_clr;
  end

  // one lane of write data per byte enable
  // byte lanes let software touch one group of eight channels at a time
  genvar lane;
  generate
    for (lane = 0; lane < IRXCMH_LANE_COUNT; lane = lane + 1) begin : g_lane
      // a lane left unselected writes zeros, which change nothing
      assign lane_bits[lane*IRXCMH_LANE_WIDTH +: IRXCMH_LANE_WIDTH] =
        avs_byteenable[lane] ? avs_writedata[lane*IRXCMH_LANE_WIDTH +: IRXCMH_LANE_WIDTH]
                             : '0;
    end
  endgenerate

  // commit at the edge where the master sees waitrequest low
  // landing on the request edge would move the mask before the master sees the answer
  assign commit_write = (bus_state_reg == BUS_ACK) && avs_write;

  // update requests to storage; unmapped writes fall away here
  assign mif.set_bits = (commit_write && hit_set) ? lane_bits : '0;
  assign mif.clr_bits = (commit_write && hit_clr) ? lane_bits : '0;

  // slave sequencing: idle with waitrequest high, one cycle of acknowledge
  // one wait state keeps readdata a flop output, at the cost of a cycle per access
  always_comb begin
    bus_state_next = bus_state_reg;
    waitrequest_next = 1'b1;
    readdata_next = readdata_reg;
    case (bus_state_reg)
      BUS_IDLE: begin
        // a request is answered on the following cycle
        if (avs_read || avs_write) begin
          bus_state_next = BUS_ACK;
          waitrequest_next = 1'b0;
          if (avs_read) begin
            // both aliases return the mask; reading leaves it alone
            readdata_next = hit_any ? mif.mask : IRXCMH_UNMAPPED_RDATA;
          end
        end
      end
      BUS_ACK: begin
        // master releases after this edge; drop back to idle
        bus_state_next = BUS_IDLE;
        waitrequest_next = 1'b1;
      end
      default: begin
        // unreachable with two states; recovers to idle all the same
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // bus flops
  // readdata resets to the unmapped value, so a read never sees leftovers from reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_state_reg <= BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= IRXCMH_UNMAPPED_RDATA;
    end else begin
      bus_state_reg <= bus_state_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  // mask storage; reset value is a parameter since the hardware leaves it open
  irxcmh_mask_bank #(
    .MASK_RESET(MASK_RESET)
  ) u_bank (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .mif(mif)
  );

  // outputs straight from flops
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;

  // bit n of the mask enables channel 32+n; receive logic drops others
  // no logic between the bank flops and these pins, so the enables never glitch
  assign upper_chan_enable = mif.mask;
  assign upper_chan_top_enable = mif.mask[IRXCMH_TOP_BIT];
  assign upper_chan_bottom_enable = mif.mask[IRXCMH_BOTTOM_BIT];

  // checks on the handshake and the stored mask
  // a master that drops a request before its acknowledge is outside this contract

  // request arrives while idle
  sequence s_req_idle;
    (avs_read || avs_write) && bus_state_reg == BUS_IDLE;
  endsequence

  // acknowledge cycle followed by idle
  sequence s_ack_once;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  // set alias write acknowledged
  sequence s_set_commit;
    avs_write && !avs_waitrequest && hit_set;
  endsequence

  // clear alias write acknowledged
  sequence s_clr_commit;
    avs_write && !avs_waitrequest && hit_clr;
  endsequence

  // write acknowledged at an unmapped address
  sequence s_stray_commit;
    avs_write && !avs_waitrequest && !hit_any;
  endsequence

  // any edge that is not a write acknowledge
  sequence s_no_commit;
    !(avs_write && !avs_waitrequest);
  endsequence

  // every request is acknowledged exactly one cycle later, for one cycle
  a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_req_idle |=> s_ack_once)
    else $error("acknowledge not one cycle after request");

  // a mapped read returns the mask held at the request
  a_read_alias_value: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s_req_idle and (avs_read && hit_any)) |=> avs_readdata == $past(upper_chan_enable))
    else $error("alias read returned wrong value");

  // a read never alters the mask
  a_read_no_effect: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (avs_read && !avs_waitrequest) |=> $stable(upper_chan_enable))
    else $error("read changed the mask");

  // an unmapped read gives zeros
  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s_req_idle and (avs_read && !hit_any)) |=> avs_readdata == IRXCMH_UNMAPPED_RDATA)
    else $error("unmapped read not zero");

  // ones at the set alias turn bits on, zeros keep them
  a_set_alias_bits: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_set_commit |=> upper_chan_enable == ($past(upper_chan_enable) | $past(lane_bits)))
    else $error("set alias result wrong");

  // ones at the clear alias turn bits off, zeros keep them
  a_clr_alias_bits: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_clr_commit |=> upper_chan_enable == ($past(upper_chan_enable) & ~$past(lane_bits)))
    else $error("clear alias result wrong");

  // a write reaches the mask only at the acknowledge edge
  a_write_wait_ack: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (avs_write && avs_waitrequest) |=> $stable(upper_chan_enable))
    else $error("mask changed before acknowledge");

  // top channel follows bit 31
  a_top_chan_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
    upper_chan_top_enable == upper_chan_enable[IRXCMH_TOP_BIT])
    else $error("channel 63 enable mismatch");

  // a one at bit 0 of the set alias enables channel 32
  a_bottom_chan_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s_set_commit and lane_bits[IRXCMH_BOTTOM_BIT]) |=> upper_chan_bottom_enable)
    else $error("channel 32 enable not set");

  // enables leave the block unchanged from the stored mask
  a_enable_vector: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (mif.set_bits == '0 && mif.clr_bits == '0) |=> $stable(upper_chan_enable)
      ##0 upper_chan_enable[IRXCMH_BOTTOM_BIT] == upper_chan_bottom_enable)
    else $error("channel enables drifted");

  // reset value lands in the mask right after reset
  a_reset_value: assert property (@(posedge clk_sys)
    $rose(rst_b) |-> upper_chan_enable == MASK_RESET)
    else $error("mask reset value wrong");

  // a write to an unmapped address is acknowledged and dropped
  a_stray_write_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_stray_commit |=> $stable(upper_chan_enable))
    else $error("unmapped write changed the mask");

  // the mask moves only at a write acknowledge edge
  a_mask_moves_commit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_no_commit |=> $stable(upper_chan_enable))
    else $error("mask changed outside a write");

  // the set alias never turns a bit off
  a_set_keeps_ones: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_set_commit |=> (($past(upper_chan_enable) & ~upper_chan_enable) == '0))
    else $error("set alias cleared a bit");

  // the clear alias never turns a bit on
  a_clr_keeps_zeros: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_clr_commit |=> ((upper_chan_enable & ~$past(upper_chan_enable)) == '0))
    else $error("clear alias set a bit");

  // a one at bit 31 of the set alias enables channel 63
  a_top_chan_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s_set_commit and lane_bits[IRXCMH_TOP_BIT]) |=> upper_chan_top_enable)
    else $error("channel 63 enable not set");

  // a one at bit 0 of the clear alias disables channel 32
  a_bottom_chan_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s_clr_commit and lane_bits[IRXCMH_BOTTOM_BIT]) |=> !upper_chan_bottom_enable)
    else $error("channel 32 enable not cleared");

  // waitrequest drops only after a request was seen
  a_ack_has_req: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(avs_waitrequest) |-> ($past(avs_read) || $past(avs_write)))
    else $error("acknowledge without a request");

  // read data move only when a read is taken
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(avs_read && bus_state_reg == BUS_IDLE) |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // a write with no byte lane selected changes nothing
  a_no_lane_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (avs_write && !avs_waitrequest && avs_byteenable == '0) |=> $stable(upper_chan_enable))
    else $error("empty write changed the mask");

  // an unselected low lane keeps channels 32 to 39
  a_lane_gate_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (avs_write && !avs_waitrequest && !avs_byteenable[0]) |=> $stable(upper_chan_enable[IRXCMH_LANE_WIDTH-1:0]))
    else $error("unselected lane changed the mask");

  // the acknowledge lasts exactly one cycle
  a_ack_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge held too long");

  // an idle slave keeps waitrequest high
  a_idle_wait_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus_state_reg == BUS_IDLE |-> avs_waitrequest)
    else $error("waitrequest low while idle");

endmodule // irxcmh_top
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the upper isochronous channel mask block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irxcmh_pkg::*;
  // clock, reset and bus stimulus
  logic clk_sys;
  logic rst_b;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  // design outputs
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] upper_chan_enable;
  logic upper_chan_top_enable;
  logic upper_chan_bottom_enable;
  // bookkeeping
  int miscompares;
  int tests_run;
  int cycles;
  logic [31:0] exp_mask; // mask as software believes it to be
  logic [31:0] rd; // last word read back

  irxcmh_top dut_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .upper_chan_enable(upper_chan_enable),
    .upper_chan_top_enable(upper_chan_top_enable),
    .upper_chan_bottom_enable(upper_chan_bottom_enable)
  );

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard; the tests need under four hundred cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      $display("mismatch %0t timeout", $time);
      conclude();
    end
  end

  // word compare
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  // single flag compare
  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  // avalon write; the model follows only mapped aliases and enabled lanes
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    for (int k = 0; k < 4; k++) m[8*k+:8] = {8{be[k]}};
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    if (a == IRXCMH_SET_OFFSET) exp_mask = exp_mask | (d & m);
    else if (a == IRXCMH_CLR_OFFSET) exp_mask = exp_mask & ~(d & m);
  endtask

  // avalon read; data taken at the edge that sees waitrequest low
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // enables settle one cycle after the write ack
  task automatic chk_en();
    @(posedge clk_sys);
    #1;
    cmp_word(upper_chan_enable, exp_mask);
    cmp_bit(upper_chan_top_enable, exp_mask[31]);
    cmp_bit(upper_chan_bottom_enable, exp_mask[0]);
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    exp_mask = 32'h0000_0000;
    repeat (6) @(posedge clk_sys);
    cmp_bit(avs_waitrequest, 1'b1);
    rst_b <= 1'b1;
    // reset value is not relied on: every bit programmed first
    bus_wr(IRXCMH_CLR_OFFSET, 32'hffff_ffff, 4'hf);
    chk_en();
    bus_wr(IRXCMH_SET_OFFSET, 32'ha5a5_0f01, 4'hf);
    chk_en();
    // both aliases read the same bits, repeated reads change nothing
    bus_rd(IRXCMH_SET_OFFSET, rd);
    cmp_word(rd, exp_mask);
    bus_rd(IRXCMH_CLR_OFFSET, rd);
    cmp_word(rd, exp_mask);
    bus_rd(IRXCMH_SET_OFFSET, rd);
    cmp_word(rd, exp_mask);
    // zeros leave bits alone; bottom off, top on
    bus_wr(IRXCMH_CLR_OFFSET, 32'h0000_0001, 4'hf);
    chk_en();
    bus_wr(IRXCMH_SET_OFFSET, 32'h8000_0000, 4'hf);
    chk_en();
    // single byte lanes, then no lane selected
    bus_wr(IRXCMH_SET_OFFSET, 32'hffff_ffff, 4'h4);
    chk_en();
    bus_wr(IRXCMH_CLR_OFFSET, 32'hffff_ffff, 4'h2);
    chk_en();
    bus_wr(IRXCMH_SET_OFFSET, 32'hffff_ffff, 4'h0);
    chk_en();
    // misaligned and neighbouring addresses touch nothing
    bus_wr(8'h71, 32'hffff_ffff, 4'hf);
    bus_wr(8'h7c, 32'hffff_ffff, 4'hf);
    chk_en();
    bus_rd(8'h78, rd);
    cmp_word(rd, 32'h0000_0000);
    // walking one: bit n alone enables channel 32+n
    for (int n = 0; n < 32; n++) begin
      bus_wr(IRXCMH_CLR_OFFSET, 32'hffff_ffff, 4'hf);
      bus_wr(IRXCMH_SET_OFFSET, 32'h0000_0001 << n, 4'hf);
      chk_en();
      bus_rd(IRXCMH_CLR_OFFSET, rd);
      cmp_word(rd, exp_mask);
    end
    conclude();
  end
endmodule // tb
`default_nettype wire
